// File: rf_frame_pkg.sv
// Purpose: shared constants for the frame timing and control block
// Assumes: 32-bit APB, byte registers in the low bits of each word
// Notes:   printed offsets are not multiples of four, so they are indices
package rf_frame_pkg;

  // register indices; byte address is four times the index
  localparam logic [7:0] IDX_GUARD_WAIT   = 8'h31;
  localparam logic [7:0] IDX_WAIT_LOW     = 8'h32;
  localparam logic [7:0] IDX_FRAME_FORMAT = 8'h33;
  localparam logic [7:0] IDX_SOF_DETECT   = 8'h34;
  localparam logic [7:0] IDX_RX_CONTROL   = 8'h35;
  localparam logic [7:0] IDX_ERROR        = 8'h0A;

  // reset values
  localparam logic [7:0] RST_GUARD_WAIT   = 8'hC0;
  localparam logic [7:0] RST_ZERO         = 8'h00;

  // guard_wait_control fields
  localparam int B_WAIT_ORIGIN = 7;
  localparam int B_WAIT_UNIT   = 6;
  localparam int B_WAIT_UP_HI  = 5;
  localparam int B_WAIT_UP_LO  = 3;
  localparam int B_STOP_HI     = 2;
  localparam int B_STOP_LO     = 0;

  // frame_format_control fields
  localparam int B_TX_PAR      = 7;
  localparam int B_RX_PAR      = 6;
  localparam logic [7:0] FRAME_FORMAT_WMASK = 8'hCF;

  // frame_start_detect_status fields
  localparam int B_SOF_EN      = 5;
  localparam int B_SOF_SEEN    = 4;
  localparam int B_SUBCARRIER_IRQ_ENABLE     = 2;
  localparam int B_SUBC_SEEN   = 1;
  localparam int B_SUBC_LIVE   = 0;

  // receive_control fields
  localparam int B_PARTIAL     = 7;
  localparam int B_CONTINUOUS  = 6;
  localparam int B_END_FORMAT  = 5;
  localparam int B_GUARD_CHECK = 4;
  localparam int B_DIST_SUP    = 3;

  // timing: one carrier-unit count is 16 carrier periods
  localparam int CARRIER_KHZ    = 13560;
  localparam int SYS_KHZ        = 100000;
  localparam int CARRIER_PER_TU = 16;
  localparam int TU_CYCLES      =
    (CARRIER_PER_TU * SYS_KHZ) / CARRIER_KHZ;
  localparam int WAIT_W         = 11;
  localparam int DIST_BYTES     = 3;

  // symbol selection and modes
  typedef enum logic [1:0] {
    SYM_NONE, SYM_ZERO, SYM_ONE, SYM_TWO
  } symbol_sel_e;
  typedef enum logic [1:0] {
    END_NONE, END_SYMBOL, END_TYPE_B
  } end_check_e;

endpackage

// File: rate_divider.sv
// Purpose: half-bit enable pulses for the selected bit stream rate
// Assumes: clk_sys at 100 MHz
// Notes:   rates are rounded down to whole cycles; 847 kBd is approximate
`timescale 1ns/1ps
module rate_divider
  import rf_frame_pkg::*;
(
  input  wire logic       clk_sys,
  input  wire logic       rst,
  input  wire logic [2:0] rate_code,
  output logic            half_bit_tick
);
  logic [15:0] cnt_r;
  logic [15:0] limit;

  // half bit period in system cycles, per rate code
  always_comb begin
    case (rate_code)
      3'h2:    limit = 16'(SYS_KHZ / 52);
      3'h3:    limit = 16'(SYS_KHZ / 104);
      3'h4:    limit = 16'(SYS_KHZ / 212);
      3'h5:    limit = 16'(SYS_KHZ / 424);
      3'h6:    limit = 16'(SYS_KHZ / 848);
      3'h7:    limit = 16'(SYS_KHZ / 1694);
      default: limit = 16'(SYS_KHZ / 212);
    endcase
  end

  // free running counter, pulse on wrap
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      cnt_r         <= 16'h0000;
      half_bit_tick <= 1'b0;
    end else if (cnt_r + 16'h0001 >= limit) begin
      cnt_r         <= 16'h0000;
      half_bit_tick <= 1'b1;
    end else begin
      cnt_r         <= cnt_r + 16'h0001;
      half_bit_tick <= 1'b0;
    end
  end
endmodule // rate_divider

// File: pin_sync.sv
// Purpose: three-flop synchroniser for one external level
// Assumes: input is asynchronous to clk_sys
// Notes:   output changes only once stages two and three agree
`timescale 1ns/1ps
module pin_sync (
  input  wire logic clk_sys,
  input  wire logic rst,
  input  wire logic din,
  output logic      dout
);
  logic s1_r;
  logic s2_r;
  logic s3_r;

  // first stage is read only by the second
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      s1_r <= 1'b0;
      s2_r <= 1'b0;
      s3_r <= 1'b0;
      dout <= 1'b0;
    end else begin
      s1_r <= din;
      s2_r <= s1_r;
      s3_r <= s2_r;
      if (s2_r == s3_r) begin
        dout <= s3_r;
      end
    end
  end
endmodule // pin_sync

// File: rf_frame_timing_control.sv
// Purpose: frame layer configuration, wait timing and detection status
// Assumes: APB slave, one clock, datapath around it supplies frame events
// Notes:   byte registers sit at four times their index
// Functional notes
// R1 - wait origin 0 times from end of transmit, 1 from end of receive
// R2 - wait unit 0 is 16 carrier periods, 1 is half a bit period
// R3 - wait is 11 bits; upper three from control bits 5 to 3
// R4 - hold off a new transmission until the wait has passed
// R5 - type B stop field: none, stop bit, stop bit plus 1 to 6 guards
// R6 - transmit parity enabled appends parity after every byte
// R7 - receive parity enabled checks parity, keeps it out of FIFO
// R8 - stop symbol field selects none or symbol 0, 1 or 2
// R9 - start symbol field selects none or symbol 0, 1 or 2
// R10 - frame start enable raises the start event on detection
// R11 - frame start seen flag sticks until software clears it
// R12 - subcarrier enable raises the same start event on detection
// R13 - subcarrier seen flag sticks until software clears it
// R14 - subcarrier live bit shows present detection unlatched
// R15 - partial byte option writes data even with incomplete last byte
// R16 - continuous reception keeps receiving after each frame
// R17 - continuous reception appends a copy of error register per frame
// R18 - end format 0 uses end symbol config, 1 uses type B end
// R19 - no end check when format 0 and end symbol bits 1:0 zero
// R20 - type B guard check flags protocol error when guard too long
// R21 - suppression drops first three bytes on error, FIFO reset
// R22 - receive rate codes 2 to 7 select 26 to 847 kBd
// R23 - writing 0 clears sticky flags; same-cycle detection wins
//
// The implementer's own choice: register access over APB.
`timescale 1ns/1ps
module rf_frame_timing_control
  import rf_frame_pkg::*;
#(
  parameter int WAIT_BITS = WAIT_W
) (
  input  wire logic        clk_sys,
  input  wire logic        rst,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // frame events from the datapath
  input  wire logic        tx_done,
  input  wire logic        rx_done,
  input  wire logic        tx_request,
  input  wire logic        sof_detect,
  input  wire logic        subc_pin,
  input  wire logic        rx_byte_err,
  input  wire logic        rx_byte_valid,
  input  wire logic        rx_frame_end,
  input  wire logic        rx_last_partial,
  input  wire logic        type_b_mode,
  input  wire logic        guard_too_long,
  input  wire logic [1:0]  end_symbol_config,
  input  wire logic [7:0]  error_reg,
  // controls toward the datapath
  output logic             tx_allowed,
  output logic [2:0]       stop_guard_length,
  output logic             tx_parity_generate,
  output logic             rx_parity_check,
  output logic [1:0]       stop_symbol_select,
  output logic [1:0]       start_symbol_select,
  output logic             rx_start_event,
  output logic             rx_keep_running,
  output logic             rx_write_partial,
  output logic             fifo_push_err,
  output logic [7:0]       fifo_err_data,
  output logic             fifo_reset,
  output logic             rx_irq_block,
  output logic             protocol_err,
  output logic [1:0]       end_check_mode,
  output logic [2:0]       bit_stream_rate
);
  initial begin
    if (WAIT_BITS != WAIT_W) $error("wait width must be eleven");
  end

  logic [7:0] guard_wait_r;
  logic [7:0] wait_low_r;
  logic [7:0] frame_fmt_r;
  logic [5:0] sof_ctl_r;  // bits 5 and 2 stored, rest unused
  logic       sof_seen_r;
  logic       subc_seen_r;
  logic [7:0] rx_ctl_r;
  logic       subcarrier_live;
  logic       half_bit_tick;
  logic [WAIT_BITS-1:0] inter_frame_wait;
  logic [WAIT_BITS-1:0] wait_cnt_r;
  logic [7:0] tu_cnt_r;
  logic       waiting_r;
  logic       unit_tick;
  logic [1:0] rx_bytes_r;
  logic       wr_en;
  logic       rd_en;
  logic [9:0] idx;
  logic       hit;
  logic       clear_sof;
  logic       clear_subc;

  assign pready  = 1'b1;
  assign idx     = paddr[11:2];
  assign wr_en   = psel && penable && pwrite;
  assign rd_en   = psel && !pwrite;
  assign hit     = (idx == 10'(IDX_GUARD_WAIT)) ||
                   (idx == 10'(IDX_WAIT_LOW)) ||
                   (idx == 10'(IDX_FRAME_FORMAT)) ||
                   (idx == 10'(IDX_SOF_DETECT)) ||
                   (idx == 10'(IDX_RX_CONTROL));
  assign pslverr = psel && penable && !hit;

  pin_sync u_subc_sync (
    .clk_sys (clk_sys),
    .rst     (rst),
    .din     (subc_pin),
    .dout    (subcarrier_live)
  );

  rate_divider u_rate (
    .clk_sys       (clk_sys),
    .rst           (rst),
    .rate_code     (rx_ctl_r[2:0]),  // see R22
    .half_bit_tick (half_bit_tick)
  );

  // configuration register writes, one word per register
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      guard_wait_r <= RST_GUARD_WAIT;
      wait_low_r   <= RST_ZERO;
      frame_fmt_r  <= RST_ZERO;
      sof_ctl_r    <= 6'h00;
      rx_ctl_r     <= RST_ZERO;
    end else if (wr_en) begin
      if (idx == 10'(IDX_GUARD_WAIT)) begin
        guard_wait_r <= pwdata[7:0];
      end else if (idx == 10'(IDX_WAIT_LOW)) begin
        wait_low_r <= pwdata[7:0];
      end else if (idx == 10'(IDX_FRAME_FORMAT)) begin
        frame_fmt_r <= pwdata[7:0] & FRAME_FORMAT_WMASK;  // reserved 0
      end else if (idx == 10'(IDX_SOF_DETECT)) begin
        sof_ctl_r[B_SOF_EN]  <= pwdata[B_SOF_EN];
        sof_ctl_r[B_SUBCARRIER_IRQ_ENABLE] <= pwdata[B_SUBCARRIER_IRQ_ENABLE];
      end else if (idx == 10'(IDX_RX_CONTROL)) begin
        rx_ctl_r <= pwdata[7:0];
      end
    end
  end

  // software clears a sticky flag by writing zero to its bit
  assign clear_sof  = wr_en && (idx == 10'(IDX_SOF_DETECT)) &&
                      !pwdata[B_SOF_SEEN];
  assign clear_subc = wr_en && (idx == 10'(IDX_SOF_DETECT)) &&
                      !pwdata[B_SUBC_SEEN];

  // sticky detection flags; a detection beats a clear in the same cycle
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      sof_seen_r  <= 1'b0;
      subc_seen_r <= 1'b0;
    end else begin
      if (sof_detect) begin
        sof_seen_r <= 1'b1;                       // see R11 see R23
      end else if (clear_sof) begin
        sof_seen_r <= 1'b0;
      end
      if (subcarrier_live) begin
        subc_seen_r <= 1'b1;                      // see R13 see R23
      end else if (clear_subc) begin
        subc_seen_r <= 1'b0;
      end
    end
  end

  // read mux; data comes from a flop, loaded in the setup cycle
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      prdata <= 32'h0000_0000;
    end else if (rd_en && !penable) begin
      if (idx == 10'(IDX_GUARD_WAIT)) begin
        prdata <= {24'h000000, guard_wait_r};
      end else if (idx == 10'(IDX_WAIT_LOW)) begin
        prdata <= {24'h000000, wait_low_r};
      end else if (idx == 10'(IDX_FRAME_FORMAT)) begin
        prdata <= {24'h000000, frame_fmt_r};
      end else if (idx == 10'(IDX_SOF_DETECT)) begin
        prdata <= {26'h0000000, sof_ctl_r[B_SOF_EN], sof_seen_r,
                   1'b0, sof_ctl_r[B_SUBCARRIER_IRQ_ENABLE], subc_seen_r,
                   subcarrier_live};              // see R14
      end else if (idx == 10'(IDX_RX_CONTROL)) begin
        prdata <= {24'h000000, rx_ctl_r};
      end else begin
        prdata <= 32'h0000_0000;
      end
    end
  end

  // wait value and its unit tick
  assign inter_frame_wait = {guard_wait_r[B_WAIT_UP_HI:B_WAIT_UP_LO],
                             wait_low_r};          // see R3
  assign unit_tick = guard_wait_r[B_WAIT_UNIT] ? half_bit_tick  // see R2
                   : (tu_cnt_r == 8'(TU_CYCLES - 1));

  // carrier unit prescaler
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      tu_cnt_r <= 8'h00;
    end else if (!waiting_r || tu_cnt_r == 8'(TU_CYCLES - 1)) begin
      tu_cnt_r <= 8'h00;
    end else begin
      tu_cnt_r <= tu_cnt_r + 8'h01;
    end
  end

  // inter-frame wait counter, started by the chosen end event
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      waiting_r  <= 1'b0;
      wait_cnt_r <= '0;
    end else if (guard_wait_r[B_WAIT_ORIGIN] ? rx_done : tx_done) begin
      waiting_r  <= (inter_frame_wait != '0);     // see R1
      wait_cnt_r <= inter_frame_wait;
    end else if (waiting_r && unit_tick) begin
      wait_cnt_r <= wait_cnt_r - 1'b1;
      if (wait_cnt_r == WAIT_BITS'(1)) begin
        waiting_r <= 1'b0;
      end
    end
  end

  assign tx_allowed = !waiting_r;                 // see R4

  // framing selections from configuration; stop guard length only in type B mode
  assign stop_guard_length   = type_b_mode ?
         guard_wait_r[B_STOP_HI:B_STOP_LO] : 3'h0;  // see R5
  assign tx_parity_generate  = frame_fmt_r[B_TX_PAR];  // see R6
  assign rx_parity_check     = frame_fmt_r[B_RX_PAR];  // see R7
  assign stop_symbol_select  = frame_fmt_r[3:2];       // see R8
  assign start_symbol_select = frame_fmt_r[1:0];       // see R9
  assign bit_stream_rate     = rx_ctl_r[2:0];

  // start event: combined from both detection sources
  assign rx_start_event =
    (sof_ctl_r[B_SOF_EN] && sof_detect) ||          // see R10
    (sof_ctl_r[B_SUBCARRIER_IRQ_ENABLE] && subcarrier_live);      // see R12

  // receive options
  assign rx_keep_running  = rx_ctl_r[B_CONTINUOUS];   // see R16
  assign rx_write_partial = rx_ctl_r[B_PARTIAL] && rx_last_partial;  // see R15
  always_comb begin
    if (rx_ctl_r[B_END_FORMAT]) begin
      end_check_mode = END_TYPE_B;                  // see R18
    end else if (end_symbol_config == 2'b00) begin
      end_check_mode = END_NONE;                    // see R19
    end else begin
      end_check_mode = END_SYMBOL;
    end
  end

  // error byte appended at each frame end in continuous mode
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      fifo_push_err <= 1'b0;
      fifo_err_data <= 8'h00;
    end else begin
      fifo_push_err <= rx_frame_end && rx_ctl_r[B_CONTINUOUS];  // see R17
      fifo_err_data <= error_reg;
    end
  end

  // guard time check and disturbance suppression
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      protocol_err <= 1'b0;
      rx_bytes_r   <= 2'h0;
      fifo_reset   <= 1'b0;
      rx_irq_block <= 1'b0;
    end else begin
      protocol_err <= type_b_mode && rx_ctl_r[B_GUARD_CHECK] &&
                      guard_too_long;              // see R20
      fifo_reset   <= 1'b0;
      if (sof_detect || rx_frame_end) begin
        rx_bytes_r   <= 2'h0;
        rx_irq_block <= 1'b0;
      end else if (rx_ctl_r[B_DIST_SUP] && rx_byte_err &&
                   rx_bytes_r < 2'(DIST_BYTES)) begin
        fifo_reset   <= 1'b1;                      // see R21
        rx_irq_block <= 1'b1;
        rx_bytes_r   <= 2'h0;
      end else if (rx_byte_valid && rx_bytes_r < 2'(DIST_BYTES)) begin
        rx_bytes_r <= rx_bytes_r + 2'h1;
      end
    end
  end

  // checks
  wait_hold_a: assert property (@(posedge clk_sys) disable iff (rst)
    waiting_r |-> !tx_allowed)                     // see R4
    else $error("transmit allowed during wait");
  wait_start_a: assert property (@(posedge clk_sys) disable iff (rst)
    (!guard_wait_r[B_WAIT_ORIGIN] && tx_done && inter_frame_wait != '0)
      |=> waiting_r)                                // see R1
    else $error("wait not started at transmit end");
  wait_val_a: assert property (@(posedge clk_sys) disable iff (rst)
    inter_frame_wait[10:8] == guard_wait_r[5:3])   // see R3
    else $error("wait upper bits misplaced");
  sof_sticky_a: assert property (@(posedge clk_sys) disable iff (rst)
    sof_detect |=> sof_seen_r)                     // see R11
    else $error("frame start flag not set");
  subc_sticky_a: assert property (@(posedge clk_sys) disable iff (rst)
    (subc_seen_r && !clear_subc) |=> subc_seen_r)  // see R13
    else $error("subcarrier flag dropped");
  set_wins_a: assert property (@(posedge clk_sys) disable iff (rst)
    (clear_subc && subcarrier_live) |=> subc_seen_r)  // see R23
    else $error("clear beat detection");
  start_evt_a: assert property (@(posedge clk_sys) disable iff (rst)
    (sof_ctl_r[B_SOF_EN] && sof_detect) |-> rx_start_event)  // see R10
    else $error("start event missing");
  err_byte_a: assert property (@(posedge clk_sys) disable iff (rst)
    (rx_frame_end && rx_ctl_r[B_CONTINUOUS]) |=>
      (fifo_push_err && fifo_err_data == $past(error_reg)))  // see R17
    else $error("error byte not appended");
  eof_skip_a: assert property (@(posedge clk_sys) disable iff (rst)
    (!rx_ctl_r[B_END_FORMAT] && end_symbol_config == 2'b00)
      |-> end_check_mode == END_NONE)              // see R19
    else $error("end check not skipped");
  cov_wait_c: cover property (@(posedge clk_sys) disable iff (rst)
    waiting_r ##1 !waiting_r);
  cov_sof_c: cover property (@(posedge clk_sys) disable iff (rst)
    rx_start_event);
  cov_sup_c: cover property (@(posedge clk_sys) disable iff (rst)
    fifo_reset);
  // a request held off by a running wait; gating itself is downstream
  cov_hold_c: cover property (@(posedge clk_sys) disable iff (rst)
    tx_request && !tx_allowed);
endmodule // rf_frame_timing_control

// File: rf_card_model.sv
// Purpose: card side model that answers with one received frame
// Assumes: frame events on clk_sys, subcarrier level asynchronous
// Notes:   bytes carry no content; only the event timing is modelled
`timescale 1ns/1ps
module rf_card_model (
  input  wire logic clk_sys,
  input  wire logic go,
  input  wire logic carrier_hold,
  output logic      sof_detect,
  output logic      subc_pin,
  output logic      rx_byte_valid,
  output logic      rx_frame_end,
  output logic      rx_done,
  output logic      busy
);
  logic frame_on;
  // subcarrier only while a card answers, or while held for a live read
  assign subc_pin = frame_on | carrier_hold;
  // one frame: subcarrier, start of frame, three bytes, end, done
  initial begin
    {frame_on, sof_detect, rx_byte_valid, rx_frame_end, rx_done} = '0;
    busy = 1'b0;
    forever begin
      @(posedge clk_sys);
      if (go === 1'b1) begin
        busy <= 1'b1;
        frame_on <= 1'b1;
        repeat (8) @(posedge clk_sys);
        sof_detect <= 1'b1;
        @(posedge clk_sys);
        sof_detect <= 1'b0;
        repeat (3) begin
          @(posedge clk_sys);
          rx_byte_valid <= 1'b1;
          @(posedge clk_sys);
          rx_byte_valid <= 1'b0;
        end
        rx_frame_end <= 1'b1;
        rx_done <= 1'b1;
        @(posedge clk_sys);
        rx_frame_end <= 1'b0;
        rx_done <= 1'b0;
        // drop the subcarrier late so the sticky flags outlive it
        repeat (2) @(posedge clk_sys);
        frame_on <= 1'b0;
        busy <= 1'b0;
      end
    end
  end
endmodule // rf_card_model

// File: rf_frame_timing_control_tb_top.sv
// Purpose: self-checking bench for frame timing and detection status
// Assumes: APB slave answers without wait states, card model on far side
// Notes:   expected results are queued and compared by the bus monitor
`timescale 1ns/1ps
module rf_frame_timing_control_tb_top
  import rf_frame_pkg::*;
;
  localparam logic [11:0] A_GW  = {2'b00, IDX_GUARD_WAIT, 2'b00};
  localparam logic [11:0] A_LO  = {2'b00, IDX_WAIT_LOW, 2'b00};
  localparam logic [11:0] A_FF  = {2'b00, IDX_FRAME_FORMAT, 2'b00};
  localparam logic [11:0] A_SOF = {2'b00, IDX_SOF_DETECT, 2'b00};
  localparam logic [11:0] A_RX  = {2'b00, IDX_RX_CONTROL, 2'b00};
  localparam int          HB7   = SYS_KHZ / (847 * 2);
  logic        clk_sys, rst, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic        tx_done, type_b_mode, go, carrier_hold, busy;
  logic        byte_err, too_long, last_part, wr_part;
  logic        fifo_rst, irq_blk, prot_err;
  logic        sof_detect, subc_pin, rx_byte_valid, rx_frame_end, rx_done;
  logic        tx_allowed, tx_parity_generate, rx_parity_check;
  logic        rx_start_event, rx_keep_running, fifo_push_err;
  logic [2:0]  stop_guard_length, bit_stream_rate;
  logic [1:0]  stop_symbol_select, start_symbol_select, end_check_mode;
  logic [1:0]  end_symbol_config;
  logic [7:0]  error_reg, fifo_err_data, r;
  logic [33:0] rd_q[$];
  logic [7:0]  err_q[$];
  int          error_cnt = 0, checked = 0, cycles = 0, seed, i;

  rf_frame_timing_control dut_u (
    .clk_sys(clk_sys), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .tx_done(tx_done),
    .rx_done(rx_done), .tx_request(1'b0), .sof_detect(sof_detect),
    .subc_pin(subc_pin), .rx_byte_err(byte_err),
    .rx_byte_valid(rx_byte_valid), .rx_frame_end(rx_frame_end),
    .rx_last_partial(last_part), .type_b_mode(type_b_mode),
    .guard_too_long(too_long), .end_symbol_config(end_symbol_config),
    .error_reg(error_reg), .tx_allowed(tx_allowed),
    .stop_guard_length(stop_guard_length),
    .tx_parity_generate(tx_parity_generate),
    .rx_parity_check(rx_parity_check),
    .stop_symbol_select(stop_symbol_select),
    .start_symbol_select(start_symbol_select),
    .rx_start_event(rx_start_event), .rx_keep_running(rx_keep_running),
    .rx_write_partial(wr_part), .fifo_push_err(fifo_push_err),
    .fifo_err_data(fifo_err_data), .fifo_reset(fifo_rst),
    .rx_irq_block(irq_blk), .protocol_err(prot_err),
    .end_check_mode(end_check_mode),
    .bit_stream_rate(bit_stream_rate)
  );

  rf_card_model card_u (
    .clk_sys(clk_sys), .go(go), .carrier_hold(carrier_hold),
    .sof_detect(sof_detect), .subc_pin(subc_pin),
    .rx_byte_valid(rx_byte_valid), .rx_frame_end(rx_frame_end),
    .rx_done(rx_done), .busy(busy)
  );

  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    checked++;
    if (g !== e) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic tally_and_finish();
    if (error_cnt == 0 && checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // the note for a read carries the expected data; writes check pslverr
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d, input logic e);
    rd_q.push_back({~w, e, d});
    @(posedge clk_sys);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    // this wait ends once pready is seen high; the bench timeout catches a hang
    do begin
      @(posedge clk_sys);
    end while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // bus and fifo monitor: oldest note is compared when a result shows
  always @(posedge clk_sys) begin : mon
    logic [33:0] nt;
    cycles++;
    if (cycles == 60000) begin
      error_cnt++;
      tally_and_finish();
    end
    if (psel === 1'b1 && penable === 1'b1 && pready === 1'b1) begin
      nt = (rd_q.size() > 0) ? rd_q.pop_front() : '1;
      if (nt[33]) chk("prdata", nt[31:0], prdata);
      chk("pslverr", nt[32], pslverr);
    end
    if (fifo_push_err === 1'b1) begin
      if (err_q.size() == 0) chk("fifo push", 0, 1);
      else chk("fifo_err_data", err_q.pop_front(), fifo_err_data);
    end
  end

  // end event, then tx_allowed must stay low about units times tick
  task automatic timer_case(input logic [7:0] gw, input logic [7:0] lo,
                            input int tick);
    int units, n;
    units = {gw[5:3], lo};
    apb(1, A_GW, gw, 0);
    apb(1, A_LO, lo, 0);
    @(posedge clk_sys);
    tx_done <= 1'b1;
    @(posedge clk_sys);
    tx_done <= 1'b0;
    n = 0;
    if (gw[7]) begin
      repeat (3) @(posedge clk_sys);
      #1 chk("tx end ignored", 1, tx_allowed);
      go <= 1'b1;
      @(posedge clk_sys);
      go <= 1'b0;
      while (rx_done !== 1'b1 && n < 100) begin
        @(posedge clk_sys);
        n++;
      end
    end
    repeat (2) @(posedge clk_sys);
    #1 chk("tx_allowed held", 0, tx_allowed);
    n = 2;
    while (tx_allowed !== 1'b1 && n < (units + 2) * tick) begin
      @(posedge clk_sys);
      #1 n++;
    end
    chk("wait not short", 1, n >= (units - 1) * tick);
    chk("wait ended", 1, tx_allowed);
    n = 0;
    while (busy === 1'b1 && n < 60) begin
      @(posedge clk_sys);
      n++;
    end
  endtask

  // one frame from the card, watching the start event on the way
  task automatic frame(input logic ev_subc, input logic ev_sof);
    int n;
    @(posedge clk_sys);
    go <= 1'b1;
    @(posedge clk_sys);
    go <= 1'b0;
    repeat (6) @(posedge clk_sys);
    #1 chk("subc event", ev_subc, rx_start_event);
    n = 0;
    while (sof_detect !== 1'b1 && n < 20) begin
      @(posedge clk_sys);
      #1 n++;
    end
    chk("sof event", ev_subc | ev_sof, rx_start_event);
    n = 0;
    while (busy === 1'b1 && n < 60) begin
      @(posedge clk_sys);
      n++;
    end
    repeat (8) @(posedge clk_sys);
  endtask

  initial begin
    seed = 96612;
    {rst, psel, penable, pwrite, tx_done, type_b_mode} = 6'b100000;
    {go, carrier_hold, end_symbol_config} = '0;
    {byte_err, too_long, last_part} = '0;
    paddr = '0;
    pwdata = '0;
    error_reg = '0;
    repeat (3) @(posedge clk_sys);
    rst <= 1'b0;
    // reset values, then an unmapped place
    apb(0, A_GW, RST_GUARD_WAIT, 0);
    apb(0, A_LO, RST_ZERO, 0);
    apb(0, A_SOF, RST_ZERO, 0);
    apb(0, A_RX, RST_ZERO, 0);
    apb(0, 12'h0F0, 32'h0000_0000, 1);
    apb(1, 12'h0F0, 32'h0000_00FF, 1);
    // every symbol code, random parity enables
    for (i = 0; i < 4; i++) begin
      r = ($random(seed) & 8'hF0) | 8'(i << 2) | 8'(3 - i);
      apb(1, A_FF, r, 0);
      apb(0, A_FF, r & FRAME_FORMAT_WMASK, 0);
      chk("tx parity", r[7], tx_parity_generate);
      chk("rx parity", r[6], rx_parity_check);
      chk("stop symbol", r[3:2], stop_symbol_select);
      chk("start symbol", r[1:0], start_symbol_select);
    end
    // stop and guard codes pass only in type B mode
    for (i = 0; i < 16; i++) begin
      type_b_mode <= i[3];
      apb(1, A_GW, 8'(i & 7), 0);
      apb(0, A_GW, 8'(i & 7), 0);
      chk("stop guard", i[3] ? (i & 7) : 0, stop_guard_length);
    end
    // end format and symbol config, every receive rate code 2 to 7
    for (i = 0; i < 8; i++) begin
      r = ($random(seed) & 8'hC0) | 8'((i & 4) << 3) | 8'(2 + i % 6);
      end_symbol_config <= i[1:0];
      apb(1, A_RX, r, 0);
      apb(0, A_RX, r, 0);
      chk("end check", i[2] ? END_TYPE_B : (i[1:0] == 0) ? END_NONE
          : END_SYMBOL, end_check_mode);
      chk("rate", 2 + i % 6, bit_stream_rate);
      chk("continuous", r[6], rx_keep_running);
    end
    // partial byte, guard check and suppression in type B mode
    apb(1, A_RX, 8'h98, 0);
    {byte_err, too_long, last_part} <= 3'b111;
    #1 chk("partial", 1, wr_part);
    @(posedge clk_sys);
    {byte_err, too_long, last_part} <= 3'b000;
    #1 chk("supp guard", 7, {fifo_rst, irq_blk, prot_err});
    @(posedge clk_sys);
    #1 chk("fifo reset pulse", 0, fifo_rst);
    // continuous off so the receive-origin frame appends nothing
    apb(1, A_RX, 8'h07, 0);
    // wait timing: carrier unit, receive origin, half-bit unit, high bits
    timer_case(8'h00, 8'h03, TU_CYCLES);
    timer_case(8'h80, 8'h02, TU_CYCLES);
    timer_case(8'h40, 8'h04, HB7);
    timer_case(8'h48, 8'h00, HB7);
    // detection flags with continuous reception appending the error copy
    apb(1, A_SOF, 8'h24, 0);
    apb(1, A_RX, 8'h40, 0);
    r = $random(seed);
    error_reg <= r;
    err_q.push_back(r);
    frame(1'b1, 1'b1);
    apb(0, A_SOF, 8'h36, 0);
    apb(1, A_SOF, 8'h24, 0);
    apb(0, A_SOF, 8'h24, 0);
    // single reception: no error copy, subcarrier alone raises nothing
    apb(1, A_RX, 8'h00, 0);
    apb(1, A_SOF, 8'h20, 0);
    frame(1'b0, 1'b1);
    carrier_hold <= 1'b1;
    repeat (8) @(posedge clk_sys);
    apb(0, A_SOF, 8'h33, 0);
    apb(1, A_SOF, 8'h20, 0);
    apb(0, A_SOF, 8'h23, 0);
    carrier_hold <= 1'b0;
    repeat (8) @(posedge clk_sys);
    apb(0, A_SOF, 8'h22, 0);
    repeat (4) @(posedge clk_sys);
    chk("err copies left", 0, err_q.size());
    chk("reads left", 0, rd_q.size());
    tally_and_finish();
  end
endmodule // rf_frame_timing_control_tb_top
